// ==== rtl/otr_ahb_slave.sv ====
// Purpose: AHB-Lite front end giving a one-cycle write strobe and a read strobe held through the read wait state
// Assumes: Single word transfers, zero wait states for writes and one for reads
// Notes: Write data is caught in the data phase after the address phase
`timescale 1ns/1ps
`default_nettype none
module otr_ahb_slave
    import otr_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    output logic wr_stb,
    output logic rd_stb,
    output logic [9:0] acc_addr
);
    logic act_ff;
    logic wr_ff;
    logic [9:0] addr_ff;
    wire take = hsel & hready & htrans[1] & (hsize == OTR_HSIZE_WORD);
    // Address phase captured; only word accesses are acted on
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            act_ff <= 1'b0;
            wr_ff <= 1'b0;
            addr_ff <= 10'h000;
        end
        else if (hready)
        begin
            act_ff <= take;
            wr_ff <= hwrite;
            addr_ff <= haddr[9:0];
        end
    end
    assign wr_stb = act_ff & wr_ff;
    assign rd_stb = act_ff & ~wr_ff;
    assign acc_addr = addr_ff;
endmodule
`default_nettype wire

// ==== rtl/otr_pkg.sv ====
// Purpose: Constants for the oscillator trim tuner
// Assumes: AHB-Lite register bus, 32-bit data, one register per word
// Notes: Register offsets are word indices as printed (0xF2..0xF4 fall on
//        word boundaries only after scaling, so they are kept as indices)
//
// How it works
// R1: The 10-bit trim code is viewed as eight sections of 128 codes, lowest section slowest.
// R2: Frequency drops back at each section boundary, so code 127 runs faster than code 128.
// R3: Software must set the fine-tuning option to 1 before tuning, or tuning is unavailable.
// R4: Software should set the CPU clock prescale to 7 before tuning to keep flash fetches legal.
// R5: Reads of the trim registers return the current 10-bit code, and software reads it first.
// R6: Software writes the whole new code into the trim registers before the apply command.
// R7: The stored code reaches the oscillator only when 0x3C is written to the command register.
// R8: Software writes no command value other than the apply code.
// R9: Code bits 9:8 sit in bits 1:0 of the high register, bits 7:0 in the low register.
// R10: The trim code field is readable and writable, documented initial value 0x00.
// R11: The command register is write-only, eight bits wide, initial value 0x00.
// R12: After tuning, software confirms the flash fetch clock stays below 8 MHz.
// R13: Reserved command values are ignored and change neither oscillator trim nor stored code.
// R14: After power-on the factory 32 MHz trim code is loaded into the trim code field.
// R15: With the fine-tuning option at 0, command writes never alter the oscillator.
// R16: Within a section each code step raises frequency by about 0.1 percent of 32 MHz.
package otr_pkg;
    localparam int unsigned OTR_CODE_W = 10;
    localparam int unsigned OTR_SECT_W = 3;
    localparam int unsigned OTR_STEP_W = 7;
    // Register indices as printed; byte address is four times the index
    localparam logic [7:0] OTR_IDX_LOW = 8'hF2;
    localparam logic [7:0] OTR_IDX_HIGH = 8'hF3;
    localparam logic [7:0] OTR_IDX_CMD = 8'hF4;
    localparam logic [7:0] OTR_IDX_STAT = 8'hF5;
    localparam logic [9:0] OTR_ADDR_LOW = {OTR_IDX_LOW, 2'b00};
    localparam logic [9:0] OTR_ADDR_HIGH = {OTR_IDX_HIGH, 2'b00};
    localparam logic [9:0] OTR_ADDR_CMD = {OTR_IDX_CMD, 2'b00};
    localparam logic [9:0] OTR_ADDR_STAT = {OTR_IDX_STAT, 2'b00};
    localparam logic [7:0] OTR_CMD_APPLY = 8'h3C;
    localparam logic [7:0] OTR_CMD_RST = 8'h00;
    localparam logic [9:0] OTR_CODE_RST = 10'h000;
    localparam logic [1:0] OTR_HIGH_MSB = 2'h1;
    // Status bit positions
    localparam int unsigned OTR_ST_EN = 0;
    localparam int unsigned OTR_ST_LOADED = 1;
    localparam int unsigned OTR_ST_REJ = 2;
    localparam logic [1:0] OTR_HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] OTR_HSIZE_WORD = 3'h2;
    typedef enum logic [1:0] {
        OTR_ST_BOOT = 2'b00,
        OTR_ST_RUN = 2'b01
    } otr_state_e;
endpackage

// ==== rtl/otr_top.sv ====
// Purpose: Oscillator fine-trim register block on AHB-Lite
// Assumes: 20 MHz hclk, asynchronous active-low reset
// Notes: The trim word drives the oscillator; section and step are split out
//
// Design decision made here: the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module otr_top
    import otr_pkg::*;
#(
    parameter int unsigned CODE_W = OTR_CODE_W
)
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic trim_feature_option,
    input wire logic [9:0] factory_trim_code,
    output logic [9:0] osc_trim_code,
    output logic [2:0] osc_trim_section,
    output logic [6:0] osc_trim_step
);
    // Only the documented code width is served by the split below
    if (CODE_W != OTR_CODE_W)
    begin : g_bad_width
        $error("CODE_W must be 10");
    end
    logic opt_s1_ff;
    logic opt_s2_ff;
    logic [9:0] fac_s1_ff;
    logic [9:0] fac_s2_ff;
    logic wr_stb;
    logic rd_stb;
    logic [9:0] acc_addr;
    logic [9:0] code_q;
    logic [9:0] osc_q;
    logic loaded_q;
    logic reject_q;
    logic [31:0] hrdata_ff;
    logic [31:0] nxt_hrdata;
    logic [9:0] osc_ff;
    logic hreadyout_ff;
    // Strap pins: two stages, left unreset so the factory code is settled at release
    always_ff @(posedge hclk)
    begin
        opt_s1_ff <= trim_feature_option;
        opt_s2_ff <= opt_s1_ff;
        fac_s1_ff <= factory_trim_code;
        fac_s2_ff <= fac_s1_ff;
    end
    // Read address phase taken: one wait state so hrdata stands in the data phase
    wire rd_take = hsel & hready & htrans[1] & ~hwrite & (hsize == OTR_HSIZE_WORD);
    otr_ahb_slave u_bus (
        .hclk(hclk),
        .hresetn(hresetn),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hready(hready),
        .wr_stb(wr_stb),
        .rd_stb(rd_stb),
        .acc_addr(acc_addr)
    );
    // Address decode of the data phase
    wire hit_low = (acc_addr == OTR_ADDR_LOW);
    wire hit_high = (acc_addr == OTR_ADDR_HIGH);
    wire hit_cmd = (acc_addr == OTR_ADDR_CMD);
    wire hit_stat = (acc_addr == OTR_ADDR_STAT);
    otr_trim_regs u_regs (
        .hclk(hclk),
        .hresetn(hresetn),
        .factory_code(fac_s2_ff),
        .feature_en(opt_s2_ff), // [R15]
        .wr_low(wr_stb & hit_low),
        .wr_high(wr_stb & hit_high),
        .wr_cmd(wr_stb & hit_cmd),
        .wdata(hwdata[7:0]),
        .code_q(code_q),
        .osc_q(osc_q),
        .loaded_q(loaded_q),
        .reject_q(reject_q)
    );
    // Read mux; command reads as zero since it is write-only
    always_comb
    begin
        nxt_hrdata = 32'h0000_0000;
        if (hit_low)
            nxt_hrdata[7:0] = code_q[7:0]; // [R5] [R9]
        else if (hit_high)
            nxt_hrdata[1:0] = code_q[9:8]; // [R5] [R9]
        else if (hit_stat)
        begin
            nxt_hrdata[OTR_ST_EN] = opt_s2_ff;
            nxt_hrdata[OTR_ST_LOADED] = loaded_q;
            nxt_hrdata[OTR_ST_REJ] = reject_q;
        end
    end
    // Registered read data and oscillator output
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hrdata_ff <= 32'h0000_0000;
            osc_ff <= OTR_CODE_RST;
            hreadyout_ff <= 1'b1;
        end
        else
        begin
            hreadyout_ff <= ~rd_take;
            if (rd_stb)
                hrdata_ff <= nxt_hrdata; // [R11]
            osc_ff <= osc_q; // [R1] [R2] [R16]
        end
    end
    // Writes take no wait state, reads one; response always OKAY
    assign hreadyout = hreadyout_ff;
    assign hresp = 1'b0;
    assign hrdata = hrdata_ff;
    // Section/step split: step rises in-section, section wraps frequency back
    assign osc_trim_code = osc_ff;
    assign osc_trim_section = osc_ff[9:7]; // [R1]
    assign osc_trim_step = osc_ff[6:0]; // [R2] [R16]
    wire apply_w = wr_stb & hit_cmd & (hwdata[7:0] == OTR_CMD_APPLY);
    property p_apply;
        @(posedge hclk) disable iff (!hresetn)
        apply_w & opt_s2_ff & loaded_q |=> ##1 osc_trim_code == $past(code_q, 2);
    endproperty
    a_apply: assert property (p_apply) else $error("apply not taken"); // [R7]
    property p_bad_cmd;
        @(posedge hclk) disable iff (!hresetn)
        wr_stb & hit_cmd & (hwdata[7:0] != OTR_CMD_APPLY) & loaded_q
        |=> ##1 $stable(osc_trim_code);
    endproperty
    a_bad_cmd: assert property (p_bad_cmd) else $error("reserved changed osc"); // [R13]
    property p_opt_off;
        @(posedge hclk) disable iff (!hresetn)
        wr_stb & hit_cmd & !opt_s2_ff & loaded_q |=> ##1 $stable(osc_trim_code);
    endproperty
    a_opt_off: assert property (p_opt_off) else $error("disabled tune changed osc"); // [R15]
    property p_rd_low;
        @(posedge hclk) disable iff (!hresetn)
        rd_stb & hit_low |=> hrdata[7:0] == $past(code_q[7:0]);
    endproperty
    a_rd_low: assert property (p_rd_low) else $error("low read wrong"); // [R5]
    property p_rd_high;
        @(posedge hclk) disable iff (!hresetn)
        rd_stb & hit_high |=> hrdata[31:2] == 30'h0 && hrdata[1:0] == $past(code_q[9:8]);
    endproperty
    a_rd_high: assert property (p_rd_high) else $error("high read wrong"); // [R9]
    property p_rd_cmd;
        @(posedge hclk) disable iff (!hresetn)
        rd_stb & hit_cmd |=> hrdata == 32'h0;
    endproperty
    a_rd_cmd: assert property (p_rd_cmd) else $error("cmd not write-only"); // [R11]
    property p_wr_low;
        @(posedge hclk) disable iff (!hresetn)
        wr_stb & hit_low & loaded_q |=> code_q[7:0] == $past(hwdata[7:0]);
    endproperty
    a_wr_low: assert property (p_wr_low) else $error("low write lost"); // [R10]
    property p_split;
        @(posedge hclk) disable iff (!hresetn)
        osc_trim_code == {osc_trim_section, osc_trim_step};
    endproperty
    a_split: assert property (p_split) else $error("section split wrong"); // [R1]
    property p_boot;
        @(posedge hclk) disable iff (!hresetn)
        $rose(loaded_q) |-> code_q == $past(fac_s2_ff);
    endproperty
    a_boot: assert property (p_boot) else $error("factory load wrong"); // [R14]
    c_apply: cover property (@(posedge hclk) apply_w & opt_s2_ff);
    c_bad: cover property (@(posedge hclk) wr_stb & hit_cmd & !apply_w);
    c_read: cover property (@(posedge hclk) rd_stb & hit_high);
endmodule
`default_nettype wire

// ==== rtl/otr_trim_regs.sv ====
// Purpose: Stored trim code and its apply path to the oscillator
// Assumes: Strobes arrive one cycle each from the bus front end
// Notes: Factory code loaded once after reset release
`timescale 1ns/1ps
`default_nettype none
module otr_trim_regs
    import otr_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [9:0] factory_code,
    input wire logic feature_en,
    input wire logic wr_low,
    input wire logic wr_high,
    input wire logic wr_cmd,
    input wire logic [7:0] wdata,
    output logic [9:0] code_q,
    output logic [9:0] osc_q,
    output logic loaded_q,
    output logic reject_q
);
    otr_state_e state_ff;
    logic [9:0] code_ff;
    logic [9:0] osc_ff;
    logic reject_ff;
    wire boot = (state_ff == OTR_ST_BOOT);
    wire apply = wr_cmd & (wdata == OTR_CMD_APPLY) & feature_en; // [R7] [R15]
    wire bad_cmd = wr_cmd & (wdata != OTR_CMD_APPLY); // [R13]
    // Factory code caught after release, never under reset
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state_ff <= OTR_ST_BOOT;
            code_ff <= OTR_CODE_RST; // [R10]
            osc_ff <= OTR_CODE_RST;
            reject_ff <= 1'b0;
        end
        else
        begin
            state_ff <= OTR_ST_RUN;
            if (boot)
            begin
                code_ff <= factory_code; // [R14]
                osc_ff <= factory_code;
            end
            else
            begin
                if (wr_low)
                    code_ff[7:0] <= wdata; // [R9]
                if (wr_high)
                    code_ff[9:8] <= wdata[OTR_HIGH_MSB:0]; // [R9]
                if (apply)
                    osc_ff <= code_ff; // [R7]
                if (bad_cmd)
                    reject_ff <= 1'b1;
            end
        end
    end
    assign code_q = code_ff;
    assign osc_q = osc_ff;
    assign loaded_q = ~boot;
    assign reject_q = reject_ff;
    property p_boot_load;
        @(posedge hclk) disable iff (!hresetn)
        boot |=> code_ff == $past(factory_code);
    endproperty
    a_boot_load: assert property (p_boot_load) else $error("factory code not loaded"); // [R14]
endmodule
`default_nettype wire

// ==== tb/otr_tb_top.sv ====
// Purpose: Self-checking bench for the oscillator trim tuner
// Assumes: Slave may stretch the data phase; read data taken at the hready edge
// Notes: Table rows cover apply, reserved codes and option off
`timescale 1ns/1ps
`default_nettype none
module oscillator_trim_tuner_tb_top
    import otr_pkg::*;
;
    localparam logic [9:0] FACT = 10'h2A5; // Arbitrary factory code
    localparam int LIMIT = 20000;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h0;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic opt = 1'b1;
    logic [9:0] osc;
    logic [2:0] sect;
    logic [6:0] step;
    logic [31:0] rdv;
    logic [9:0] exp_osc;
    int fails = 0;
    int n_tests = 0;
    int cyc = 0;
    // Each row is {option, command, code}
    localparam logic [18:0] ROWS [7] = '{
        {1'b1, 8'h3C, 10'h07F}, {1'b1, 8'h3C, 10'h080}, {1'b1, 8'h55, 10'h3FF},
        {1'b0, 8'h3C, 10'h3FF}, {1'b1, 8'h3C, 10'h380}, {1'b1, 8'h3C, 10'h3FF},
        {1'b1, 8'h00, 10'h155}};

    otr_top i_otr_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .trim_feature_option(opt), .factory_trim_code(FACT), .osc_trim_code(osc),
        .osc_trim_section(sect), .osc_trim_step(step));

    // Clock, 50 ns period
    initial
    begin
        forever #25 hclk = ~hclk;
    end

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Hang guard sized well above the sequence length
    always @(posedge hclk)
    begin
        cyc <= cyc + 1;
        if (cyc == LIMIT)
        begin
            fails++;
            stop_test();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Bounded wait for hready at a rising edge
    task automatic wait_rdy();
        int n;
        n = 0;
        do
        begin
            @(posedge hclk);
            n++;
        end
        while (hreadyout !== 1'b1 && n < 50);
    endtask

    // One single-word transfer; read data taken once the data-phase edge has landed
    task automatic bus(input logic wr, input logic [31:0] addr, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= addr;
        htrans <= OTR_HTRANS_NONSEQ;
        hwrite <= wr;
        hsize <= OTR_HSIZE_WORD;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy();
        rdv = hrdata;
        chk({31'h0, hresp}, 32'h0);
    endtask

    task automatic rd_chk(input logic [31:0] addr, input logic [31:0] exp);
        bus(1'b0, addr, 32'h0);
        chk(rdv, exp);
    endtask

    // Reset held 20 cycles, then three edges before the first request
    task automatic do_reset();
        hresetn <= 1'b0;
        repeat (20) @(posedge hclk);
        chk({22'h0, osc}, 32'h0);
        hresetn <= 1'b1;
        repeat (3) @(posedge hclk);
        exp_osc = FACT;
    endtask

    task automatic osc_chk();
        chk({22'h0, osc}, {22'h0, exp_osc});
        chk({29'h0, sect}, {29'h0, exp_osc[9:7]});
        chk({25'h0, step}, {25'h0, exp_osc[6:0]});
    endtask

    initial
    begin
        do_reset();
        osc_chk();
        rd_chk(OTR_ADDR_LOW, {24'h0, FACT[7:0]});
        rd_chk(OTR_ADDR_HIGH, {30'h0, FACT[9:8]});
        rd_chk(OTR_ADDR_CMD, 32'h0);
        rd_chk(32'h0000_0100, 32'h0);
        rd_chk(OTR_ADDR_STAT, 32'h3);
        // Table of tuning attempts
        for (int i = 0; i < 7; i++)
        begin
            // Prescale and fetch-clock limits live outside this block
            opt <= ROWS[i][18];
            repeat (3) @(posedge hclk);
            bus(1'b1, OTR_ADDR_LOW, {24'hFFFFFF, ROWS[i][7:0]});
            bus(1'b1, OTR_ADDR_HIGH, {30'h3FFFFFFF, ROWS[i][9:8]});
            bus(1'b1, OTR_ADDR_CMD, {24'h0, ROWS[i][17:10]});
            if (ROWS[i][18] && ROWS[i][17:10] == OTR_CMD_APPLY)
                exp_osc = ROWS[i][9:0];
            repeat (4) @(posedge hclk);
            osc_chk();
            rd_chk(OTR_ADDR_LOW, {24'h0, ROWS[i][7:0]});
            rd_chk(OTR_ADDR_HIGH, {30'h0, ROWS[i][9:8]});
        end
        rd_chk(OTR_ADDR_STAT, 32'h7);
        // Mid-run reset restores factory code and clears sticky flag
        do_reset();
        osc_chk();
        rd_chk(OTR_ADDR_STAT, 32'h3);
        stop_test();
    end
endmodule
`default_nettype wire
